/* File: bench/mipg_core_model.sv */
// Core and request source model on the far side of the gate
`timescale 1ns/100ps
module mipg_core_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  cmdSrc,
  input  wire logic        cmdNmi,
  input  wire logic        cmdStep,
  input  wire logic        cmdLoad,
  input  wire logic [31:0] cmdData,
  output logic      [7:0]  srcReq,
  output logic             nmiReq,
  output logic             instrDone,
  output logic             pswLoadEn,
  output logic      [31:0] pswLoadData
);
  // ==========================================================================
  // Sources pulse when told; the core marks one instruction end per step
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      srcReq      <= 8'h00;
      nmiReq      <= 1'b0;
      instrDone   <= 1'b0;
      pswLoadEn   <= 1'b0;
      pswLoadData <= 32'h00000000;
    end else begin
      srcReq      <= cmdSrc;
      nmiReq      <= cmdNmi;
      instrDone   <= cmdStep;
      pswLoadEn   <= cmdLoad;
      pswLoadData <= cmdLoad ? cmdData : ~pswLoadData;  // Junk when not loading
    end
  end
endmodule : mipg_core_model

/* File: bench/tb_maskable_irq_priority_gate.sv */
// Self-checking testbench for the maskable interrupt priority gate
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin num_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_maskable_irq_priority_gate;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, pswLoadData, cmdData = 32'h0, rd;
  logic        pready, pslverr, nmiReq, instrDone, pswLoadEn, intTake, nmiTake, irq, er;
  logic [7:0]  srcReq, cmdSrc = 8'h00;
  logic        cmdNmi = 1'b0, cmdStep = 1'b0, cmdLoad = 1'b0;
  logic [2:0]  intSrcId, lastId;
  logic [mipg_pkg::LVL_W-1:0] intLevel, lastLvl;
  int          num_errors = 0, checks = 0, takeCnt = 0, nmiCnt = 0;
  // ==========================================================================
  // Clock, design and far side
  always #20 ref_clk = ~ref_clk;
  mipg_gate i_dut (.ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .srcReq(srcReq), .nmiReq(nmiReq), .instrDone(instrDone),
    .pswLoadEn(pswLoadEn), .pswLoadData(pswLoadData), .intTake(intTake),
    .intSrcId(intSrcId), .intLevel(intLevel), .nmiTake(nmiTake), .irq(irq));
  mipg_core_model i_core (.ref_clk(ref_clk), .reset(reset), .cmdSrc(cmdSrc), .cmdNmi(cmdNmi),
    .cmdStep(cmdStep), .cmdLoad(cmdLoad), .cmdData(cmdData), .srcReq(srcReq),
    .nmiReq(nmiReq), .instrDone(instrDone), .pswLoadEn(pswLoadEn),
    .pswLoadData(pswLoadData));
  // Count taken requests and keep the last one seen
  always @(posedge ref_clk) begin
    if (intTake === 1'b1) begin
      takeCnt++;
      lastId = intSrcId;
      lastLvl = intLevel;
    end
    if (nmiTake === 1'b1) nmiCnt++;
  end
  // ==========================================================================
  // Bus and far-side helpers
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask : rdchk
  task pulse(input logic [7:0] s, input logic n, input logic st, input logic ld);
    @(posedge ref_clk);
    cmdSrc <= s;
    cmdNmi <= n;
    cmdStep <= st;
    cmdLoad <= ld;
    @(posedge ref_clk);
    cmdSrc <= 8'h00;
    cmdNmi <= 1'b0;
    cmdStep <= 1'b0;
    cmdLoad <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : pulse
  // ==========================================================================
  // Scenarios
  task t_reset;
    rdchk("psw", 8'h00, 32'h0);
    rdchk("mask", 8'h08, 32'h0);
    rdchk("ctrl7", 8'h2c, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("slverr", 1'b1, er)
    `CHK("unmapped", 32'h0, rd)
  endtask : t_reset
  task t_pending;
    wr(8'h18, 32'h5);
    pulse(8'h04, 1'b0, 1'b0, 1'b0);
    pulse(8'h00, 1'b0, 1'b1, 1'b0);
    `CHK("takes", 0, takeCnt)
    rdchk("req set", 8'h18, 32'hd);
    wr(8'h00, 32'h70);
    rdchk("ctrl kept", 8'h18, 32'hd);
    wr(8'h18, 32'h5);
    rdchk("req clr", 8'h18, 32'h5);
    wr(8'h18, 32'hd);
    rdchk("req no set", 8'h18, 32'h5);
  endtask : t_pending
  task t_levels;
    int exp;
    exp = 0;
    for (int t = 0; t < 8; t++) begin
      for (int l = t; l < 8 && l <= t + 1; l++) begin
        wr(8'h00, 32'h0);
        wr(8'h14, l);
        pulse(8'h02, 1'b0, 1'b0, 1'b0);
        wr(8'h00, (t << 4) | 1);
        pulse(8'h00, 1'b0, 1'b1, 1'b0);
        if (l > t) exp++;
        `CHK("accept", exp, takeCnt)
        if (l > t) begin
          `CHK("lvl", l, lastLvl)
          rdchk("psw thr", 8'h00, l << 4);
          rdchk("req auto", 8'h14, l);
        end
      end
    end
  endtask : t_levels
  task t_pick;
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h1c, 32'h4);
    wr(8'h24, 32'h6);
    wr(8'h28, 32'h6);
    wr(8'h08, 32'h1);
    pulse(8'h68, 1'b0, 1'b0, 1'b0);
    wr(8'h00, 32'h1);
    pulse(8'h00, 1'b0, 1'b1, 1'b0);
    `CHK("win id", 5, lastId)
    `CHK("irq on", 1'b1, irq)
    rdchk("stat", 8'h04, 32'h1);
    wr(8'h04, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK("irq off", 1'b0, irq)
    wr(8'h00, 32'h61);
    pulse(8'h00, 1'b0, 1'b1, 1'b0);
    `CHK("equal lvl", 0, lastId - 5)
    cmdData <= 32'h31;
    pulse(8'h00, 1'b0, 1'b0, 1'b1);
    pulse(8'h00, 1'b0, 1'b1, 1'b0);
    `CHK("restored", 6, lastId)
  endtask : t_pick
  task t_nmi;
    wr(8'h00, 32'h70);
    pulse(8'h00, 1'b1, 1'b0, 1'b0);
    pulse(8'h00, 1'b0, 1'b1, 1'b0);
    `CHK("nmi", 1, nmiCnt)
    rdchk("psw nmi", 8'h00, 32'h70);
    rdchk("stat nmi", 8'h04, 32'h3);
  endtask : t_nmi
  task t_race;
    fork
      wr(8'h1c, 32'h4);
      pulse(8'h08, 1'b0, 1'b0, 1'b0);
    join
    rdchk("req race", 8'h1c, 32'hc);
  endtask : t_race
  task print_verdict;
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_pending();
    t_levels();
    t_pick();
    t_race();
    t_nmi();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    print_verdict();
  end
endmodule : tb_maskable_irq_priority_gate

/* File: rtl/mipg_gate.sv */
// Maskable interrupt acceptance gate with APB registers
//
// What this block does
// (RULE1) One global enable flag gates all maskable requests and resets to 0.
// (RULE2) A source request sets its request bit whatever the flag or levels say.
// (RULE3) Hardware clears the request bit when that request is accepted.
// (RULE4) Software may clear a request bit but writing 1 never creates a request.
// (RULE5) A 3-bit priority field gives levels 0 to 7, 7 highest, 0 disabled.
// (RULE6) A pending request is accepted only if its level is above the threshold.
// (RULE7) Threshold 000 admits level 1 and up, each step one more, 111 blocks all.
// (RULE8) Flag, request bits, priority fields and threshold change independently.
// (RULE9) Request and priority sit per source; flag and threshold in the status word.
// (RULE10) Non-maskable requests ignore flag, priority fields and threshold.
// (RULE11) Software rewrites a control word only when no request can arrive then.
// (RULE12) Software pads re-enabling after a control write with two no-ops or a read.
// (RULE13) A hardware request in the cycle of a control rewrite is kept, not lost.
// (RULE14) Accepting a maskable request loads the threshold with its level.
// (RULE15) Among eligible requests the highest level wins, ties to the lowest index.
// (RULE16) Acceptance is decided at an instruction end and shown the next cycle.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module mipg_gate #(
  parameter int NUM_SRC = 8,
  parameter int ID_W    = 3
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic [7:0]              paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [NUM_SRC-1:0]      srcReq,
  input  wire logic                    nmiReq,
  input  wire logic                    instrDone,
  input  wire logic                    pswLoadEn,
  input  wire logic [31:0]             pswLoadData,
  output logic                         intTake,
  output logic [ID_W-1:0]              intSrcId,
  output logic [mipg_pkg::LVL_W-1:0]   intLevel,
  output logic                         nmiTake,
  output logic                         irq
);
  localparam int LW = mipg_pkg::LVL_W;

  // ==========================================================================
  // State
  logic                    enable_q;
  logic [LW-1:0]           thr_q;
  logic [NUM_SRC-1:0]      req_q;
  logic [LW-1:0]           lvl_q [NUM_SRC];
  logic                    nmiPend_q;
  logic [mipg_pkg::STAT_W-1:0] stat_q;
  logic [mipg_pkg::STAT_W-1:0] stat_d;
  logic [mipg_pkg::STAT_W-1:0] mask_q;
  logic [31:0]             prdata_q;
  logic                    pready_q;
  logic                    pslverr_q;
  logic                    intTake_q;
  logic [ID_W-1:0]         intSrcId_q;
  logic [LW-1:0]           intLevel_q;
  logic                    nmiTake_q;
  logic                    irq_q;

  // Control word index from a byte address, valid flag in the top bit
  function automatic logic [ID_W:0] ctrl_index(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - mipg_pkg::OFS_CTRL_BASE;
    if (a >= mipg_pkg::OFS_CTRL_BASE && rel[1:0] == 2'h0 &&
        32'(rel[7:2]) < NUM_SRC)
      return {1'b1, ID_W'(rel[7:2])};
    return '0;
  endfunction : ctrl_index

  // ==========================================================================
  // APB decode
  wire          setupPh = psel && !penable;
  wire          wrDo    = psel && penable && pready_q && pwrite;
  wire [ID_W:0] ctrlSel = ctrl_index(paddr);
  wire          ctrlHit = ctrlSel[ID_W];
  wire [ID_W-1:0] ctrlIdx = ctrlSel[ID_W-1:0];
  wire          pswHit  = paddr == mipg_pkg::OFS_PSW;
  wire          statHit = paddr == mipg_pkg::OFS_STAT;
  wire          maskHit = paddr == mipg_pkg::OFS_MASK;
  wire          anyHit  = ctrlHit || pswHit || statHit || maskHit;

  // Read data selection
  wire [31:0] pswWord  = {24'h000000, 1'b0, thr_q, 3'h0, enable_q};  // [RULE9]
  wire [31:0] ctrlWord = {28'h0000000, req_q[ctrlIdx], lvl_q[ctrlIdx]};  // [RULE9]
  wire [31:0] rdMux = pswHit  ? pswWord :
                      statHit ? {30'h00000000, stat_q} :
                      maskHit ? {30'h00000000, mask_q} :
                      ctrlHit ? ctrlWord : 32'h00000000;

  // APB answer: data sampled in setup, ready in the access cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setupPh;
      pslverr_q <= setupPh && !anyHit;
      if (setupPh) begin
        prdata_q <= rdMux;
      end
    end
  end

  // ==========================================================================
  // Eligibility and pick
  logic [NUM_SRC-1:0]    elig;
  logic [NUM_SRC*LW-1:0] lvlFlat;
  logic                  anyValid;
  logic [ID_W-1:0]       winIdx;
  logic [LW-1:0]         winLvl;

  // Level 0 never beats any threshold, so it stays disabled
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      lvlFlat[i*LW +: LW] = lvl_q[i];
      elig[i] = req_q[i] && enable_q && (lvl_q[i] > thr_q);  // [RULE1] [RULE5] [RULE6] [RULE7]
    end
  end

  mipg_pick #(.N(NUM_SRC), .LW(LW), .IDW(ID_W)) u_pick (
    .elig     (elig),
    .lvlFlat  (lvlFlat),
    .anyValid (anyValid),
    .winIdx   (winIdx),
    .winLvl   (winLvl)
  );

  // ==========================================================================
  // Checking aid: eligible sources that beat or tie ahead of the winner
  logic [NUM_SRC-1:0] aboveWin;
  logic [NUM_SRC-1:0] tieAhead;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      aboveWin[i] = elig[i] && (lvl_q[i] > winLvl);
      tieAhead[i] = elig[i] && (lvl_q[i] == winLvl) && (ID_W'(i) < winIdx);
    end
  end

  // Decisions at an instruction end; the non-maskable one goes first
  wire acceptNmi  = instrDone && nmiPend_q;  // [RULE10]
  wire acceptMask = instrDone && !nmiPend_q && anyValid;  // [RULE16]

  // ==========================================================================
  // Per-source request bits and priority fields
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      req_q <= '0;
      for (int i = 0; i < NUM_SRC; i++) lvl_q[i] <= mipg_pkg::RST_LVL;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (srcReq[i]) begin
          req_q[i] <= 1'b1;  // [RULE2] [RULE13]
        end else if (acceptMask && winIdx == ID_W'(i)) begin
          req_q[i] <= 1'b0;  // [RULE3]
        end else if (wrDo && ctrlHit && ctrlIdx == ID_W'(i) && !pwdata[mipg_pkg::CTRL_REQ]) begin
          req_q[i] <= 1'b0;  // [RULE4]
        end
        if (wrDo && ctrlHit && ctrlIdx == ID_W'(i)) begin
          lvl_q[i] <= pwdata[mipg_pkg::CTRL_LVL +: LW];  // [RULE8]
        end
      end
    end
  end

  // Status word: acceptance wins, then core restore, then software write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      enable_q <= mipg_pkg::RST_EN;  // [RULE1]
      thr_q    <= mipg_pkg::RST_THR;
    end else if (acceptMask) begin
      enable_q <= 1'b0;
      thr_q    <= winLvl;  // [RULE14]
    end else if (pswLoadEn) begin
      enable_q <= pswLoadData[mipg_pkg::PSW_EN];
      thr_q    <= pswLoadData[mipg_pkg::PSW_THR +: LW];
    end else if (wrDo && pswHit) begin
      enable_q <= pwdata[mipg_pkg::PSW_EN];  // [RULE8]
      thr_q    <= pwdata[mipg_pkg::PSW_THR +: LW];
    end
  end

  // Non-maskable pending flag and core-facing results
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      nmiPend_q  <= 1'b0;
      intTake_q  <= 1'b0;
      intSrcId_q <= '0;
      intLevel_q <= '0;
      nmiTake_q  <= 1'b0;
    end else begin
      nmiPend_q <= nmiReq || (nmiPend_q && !acceptNmi);
      intTake_q <= acceptMask;  // [RULE16]
      nmiTake_q <= acceptNmi;
      if (acceptMask) begin
        intSrcId_q <= winIdx;
        intLevel_q <= winLvl;
      end
    end
  end

  // ==========================================================================
  // Event status, mask and interrupt line; a new event beats its clear
  wire [mipg_pkg::STAT_W-1:0] evt = {acceptNmi, acceptMask};
  wire [mipg_pkg::STAT_W-1:0] w1c = (wrDo && statHit) ? pwdata[mipg_pkg::STAT_W-1:0] : '0;
  assign stat_d = (stat_q & ~w1c) | evt;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stat_q <= '0;
      mask_q <= mipg_pkg::RST_MASK;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= |(stat_d & ((wrDo && maskHit) ? pwdata[mipg_pkg::STAT_W-1:0] : mask_q));
      if (wrDo && maskHit) begin
        mask_q <= pwdata[mipg_pkg::STAT_W-1:0];
      end
    end
  end

  // Outputs
  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign intTake  = intTake_q;
  assign intSrcId = intSrcId_q;
  assign intLevel = intLevel_q;
  assign nmiTake  = nmiTake_q;
  assign irq      = irq_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_take_next_cycle: assert property ( // [RULE16]
    instrDone && !nmiPend_q && anyValid |=> intTake && intLevel == $past(winLvl))
    else $error("Accepted request not shown the next cycle");
  a_level_above_thr: assert property (intTake |-> intLevel > $past(thr_q, 1)) // [RULE6]
    else $error("Accepted level not above threshold");
  a_thr_loaded: assert property (acceptMask |=> thr_q == $past(winLvl) && !enable_q) // [RULE14]
    else $error("Threshold not loaded on acceptance");
  a_req_cleared: assert property ( // [RULE3]
    acceptMask && srcReq == '0 |=> !req_q[$past(winIdx)])
    else $error("Request bit kept after acceptance");
  a_req_set_wins: assert property ( // [RULE2]
    srcReq != '0 |=> (req_q & $past(srcReq)) == $past(srcReq))
    else $error("Hardware request lost");
  a_flag_gates: assert property (!enable_q && instrDone |=> !intTake) // [RULE1]
    else $error("Maskable take with flag clear");
  a_thr_blocks: assert property (thr_q == mipg_pkg::THR_BLOCK && instrDone |=> !intTake) // [RULE7]
    else $error("Take while threshold blocks all");
  a_nmi_bypass: assert property (instrDone && nmiPend_q |=> nmiTake && !intTake) // [RULE10]
    else $error("Non-maskable request not taken");
  a_psw_isolated: assert property ( // [RULE8]
    wrDo && pswHit && !acceptMask |=> lvlFlat == $past(lvlFlat))
    else $error("Status word write changed a priority field");
  a_no_sw_set: assert property ( // [RULE4]
    wrDo && ctrlHit && srcReq == '0 && !req_q[ctrlIdx] |=> !req_q[$past(ctrlIdx)])
    else $error("Software write created a request");
  a_pick_highest: assert property ( // [RULE15]
    acceptMask |-> aboveWin == '0 && tieAhead == '0)
    else $error("Picked request is not the highest eligible");
  a_level_nonzero: assert property (intTake |-> intLevel != '0) // [RULE5]
    else $error("Level zero request was taken");
  a_take_single: assert property (intTake |=> !intTake) // [RULE14]
    else $error("Maskable take repeated in the next cycle");
  a_take_held: assert property (!acceptMask |=> $stable(intSrcId) && $stable(intLevel))
    else $error("Taken source or level changed without a take");
  a_idle_no_take: assert property (!instrDone |=> !intTake && !nmiTake) // [RULE16]
    else $error("Take without an instruction end");
  a_nmi_held: assert property (nmiPend_q && !instrDone |=> nmiPend_q) // [RULE10]
    else $error("Pending non-maskable request dropped");
  a_nmi_keeps_psw: assert property ( // [RULE10]
    acceptNmi && !pswLoadEn && !(wrDo && pswHit) |=>
      thr_q == $past(thr_q) && enable_q == $past(enable_q))
    else $error("Non-maskable take changed the status word");
  a_stat_set_wins: assert property (
    evt != '0 |=> (stat_q & $past(evt)) == $past(evt))
    else $error("Event status lost to its clear");
  a_irq_follows: assert property (irq == |(stat_q & mask_q))
    else $error("Interrupt line disagrees with status and mask");
  a_pready_setup: assert property (pready |-> $past(psel && !penable))
    else $error("Ready without a setup cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("Error flag without ready");

  // ==========================================================================
  // Main scenarios
  c_mask_take: cover property (acceptMask ##1 intTake);
  c_nmi_take:  cover property (acceptNmi ##1 nmiTake);
  c_set_vs_clear: cover property (
    wrDo && ctrlHit && srcReq[ctrlIdx] && !pwdata[mipg_pkg::CTRL_REQ]);
  c_irq_rise:  cover property ($rose(irq));
  c_nmi_over_mask: cover property (acceptNmi && anyValid);
endmodule : mipg_gate

/* File: rtl/mipg_pick.sv */
// Priority pick among eligible pending requests
`timescale 1ns/100ps
module mipg_pick #(
  parameter int N   = 8,
  parameter int LW  = 3,
  parameter int IDW = 3
) (
  input  wire logic [N-1:0]    elig,
  input  wire logic [N*LW-1:0] lvlFlat,
  output logic                 anyValid,
  output logic [IDW-1:0]       winIdx,
  output logic [LW-1:0]        winLvl
);
  // Scan downward so that on equal levels the lowest index wins
  always_comb begin
    anyValid = 1'b0;
    winIdx   = '0;
    winLvl   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (elig[i] && (!anyValid || lvlFlat[i*LW +: LW] >= winLvl)) begin  // [RULE15]
        anyValid = 1'b1;
        winIdx   = IDW'(i);
        winLvl   = lvlFlat[i*LW +: LW];
      end
    end
  end
endmodule : mipg_pick

/* File: rtl/mipg_pkg.sv */
// Shared constants for the maskable interrupt priority gate
package mipg_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_PSW       = 8'h00;  // Enable flag and threshold
  localparam logic [7:0] OFS_STAT      = 8'h04;  // Sticky event status, write one to clear
  localparam logic [7:0] OFS_MASK      = 8'h08;  // Event mask
  localparam logic [7:0] OFS_CTRL_BASE = 8'h10;  // First per-source control word
  // ==========================================================================
  // Field positions and widths
  localparam int LVL_W     = 3;   // Priority level and threshold width
  localparam int PSW_EN    = 0;   // Global enable flag bit
  localparam int PSW_THR   = 4;   // Threshold low bit
  localparam int CTRL_LVL  = 0;   // Priority field low bit
  localparam int CTRL_REQ  = 3;   // Request bit
  localparam int STAT_W    = 2;   // Status and mask width
  localparam int STAT_ACC  = 0;   // Maskable request accepted
  localparam int STAT_NMI  = 1;   // Non-maskable request taken
  // ==========================================================================
  // Reset values
  localparam logic             RST_EN   = 1'b0;
  localparam logic [LVL_W-1:0] RST_THR  = 3'h0;
  localparam logic [LVL_W-1:0] RST_LVL  = 3'h0;
  localparam logic [STAT_W-1:0] RST_MASK = 2'h0;
  localparam logic [LVL_W-1:0] THR_BLOCK = 3'h7;  // Threshold that blocks everything
endpackage : mipg_pkg
